// >>> src/pdsp_cfg.svh
// Purpose: named constants of the position deviation and status parameter set
// Assumes: parameter addresses are the fieldbus register addresses
// Notes: included by the package and by the top module
`ifndef PDSP_CFG_SVH
`define PDSP_CFG_SVH

// parameter addresses
`define PDSP_A_RESCALE_STATE 16'h042A
`define PDSP_A_RESCALE_ERROR 16'h042C
`define PDSP_A_CMP_FLAGS 16'h0B02
`define PDSP_A_SETP_INT 16'h1E12
`define PDSP_A_SETP_USR 16'h1E18
`define PDSP_A_TOTAL_DEV_USR 16'h1E28
`define PDSP_A_PEAK_USR 16'h1E2A
`define PDSP_A_LOAD_DEV_USR 16'h1E2C
`define PDSP_A_PEAK_REV 16'h1E36

// rescale state codes
`define PDSP_ST_ACTIVE 3'h0
`define PDSP_ST_DONE_OK 3'h2
`define PDSP_ST_ERROR 3'h3
`define PDSP_ST_INIT_OK 3'h4

// rescale error info field positions
`define PDSP_ERR_ADDR_LSB 0
`define PDSP_ERR_ADDR_MSB 15
`define PDSP_ERR_SET_LSB 16
`define PDSP_ERR_SET_MSB 31

// values and limits
`define PDSP_ZERO32 32'h0000_0000
`define PDSP_USR_MAX 32'h7FFF_FFFF
`define PDSP_USR_MIN 32'h8000_0000
`define PDSP_SIGN_BIT 31

`endif

// >>> src/pdsp_pkg.sv
// Purpose: types shared by the position deviation and status parameter set
// Assumes: constants come from the cfg header
// Notes: access request and rescale report travel as packed structs
`include "pdsp_cfg.svh"

package pdsp_pkg;

    // rescale state, codes as reported to the master
    typedef enum logic [2:0] {
        PDSP_RS_ACTIVE = `PDSP_ST_ACTIVE,
        PDSP_RS_DONE = `PDSP_ST_DONE_OK,
        PDSP_RS_ERROR = `PDSP_ST_ERROR,
        PDSP_RS_INIT = `PDSP_ST_INIT_OK
    } pdsp_rs_state_t;

    // one parameter access from the fieldbus side
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [31:0] data;
    } pdsp_req_t;

    // rescale events from the recalculation engine
    typedef struct packed {
        logic start;
        logic done;
        logic fail;
        logic init_ok;
        logic [15:0] err_param;
        logic [15:0] err_set;
    } pdsp_rescale_t;

endpackage : pdsp_pkg

// >>> src/pdsp_top.sv
// Purpose: position deviation, peak tracking, rescale status and compare flags
// Assumes: all inputs synchronous to clk; one access per cycle from the fieldbus stack
// Notes: read data appears one cycle after the request; writes only clear peaks
`timescale 1ns/100ps
`include "pdsp_cfg.svh"

module pdsp_top import pdsp_pkg::*; #(
    parameter int DATA_W = 32,
    parameter int ADDR_W = 16,
    parameter int CHAN_N = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire pdsp_req_t req,
    input wire logic [DATA_W-1:0] ref_pos_usr,
    input wire logic [DATA_W-1:0] ref_pos_int,
    input wire logic [DATA_W-1:0] load_pos_usr,
    input wire logic [DATA_W-1:0] dyn_dev_usr,
    input wire logic [DATA_W-1:0] load_dev_rev,
    input wire pdsp_rescale_t rescale,
    input wire logic [CHAN_N-1:0] cmp_met,
    output logic [DATA_W-1:0] rd_data_q,
    output logic rd_valid_q,
    output logic acc_err_q,
    output logic [DATA_W-1:0] follow_dev_q
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (DATA_W != 32 || ADDR_W != 16 || CHAN_N < 1 || CHAN_N > 16) begin : g_chk
        $error("pdsp_top: unsupported parameter values");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] ref_usr_q;
    logic [DATA_W-1:0] ref_int_q;
    logic [DATA_W-1:0] load_dev_d;
    logic [DATA_W-1:0] load_dev_q;
    logic [DATA_W-1:0] total_dev_q;
    logic [DATA_W-1:0] abs_usr;
    logic [DATA_W-1:0] abs_rev;
    logic [DATA_W-1:0] peak_usr_q;
    logic [DATA_W-1:0] peak_rev_q;
    logic [DATA_W-1:0] peak_usr_base;
    logic [DATA_W-1:0] peak_rev_base;
    logic [DATA_W-1:0] err_info_q;
    logic [CHAN_N-1:0] flags_q;
    logic clr_usr;
    logic clr_rev;
    logic hit;
    logic ro_hit;
    pdsp_rs_state_t rs_q;
    logic [DATA_W-1:0] rd_mux;

    // ----------------------------------------------------------------
    // deviations
    // ----------------------------------------------------------------
    // signed difference wraps in two's complement like the controller
    assign load_dev_d = ref_pos_usr - load_pos_usr;

    // reference and deviation samples
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_usr_q <= `PDSP_ZERO32;
            ref_int_q <= `PDSP_ZERO32;
            load_dev_q <= `PDSP_ZERO32;
            total_dev_q <= `PDSP_ZERO32;
        end else begin
            ref_usr_q <= ref_pos_usr;
            ref_int_q <= ref_pos_int;
            load_dev_q <= load_dev_d;
            total_dev_q <= load_dev_d + dyn_dev_usr;
        end
    end

    // following error monitor gets the load deviation only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            follow_dev_q <= `PDSP_ZERO32;
        end else begin
            follow_dev_q <= load_dev_d;
        end
    end

    // ----------------------------------------------------------------
    // peak tracking
    // ----------------------------------------------------------------
    // magnitude in user units, most negative value saturates
    always_comb begin
        if (!load_dev_q[`PDSP_SIGN_BIT]) begin
            abs_usr = load_dev_q;
        end else if (load_dev_q == `PDSP_USR_MIN) begin
            abs_usr = `PDSP_USR_MAX;
        end else begin
            abs_usr = `PDSP_ZERO32 - load_dev_q;
        end
    end

    // revolution magnitude is unsigned, so -2^31 is exact
    assign abs_rev = load_dev_rev[`PDSP_SIGN_BIT] ? (`PDSP_ZERO32 - load_dev_rev) : load_dev_rev;

    // a write clears; the sample of the same cycle still counts
    assign clr_usr = req.wr && (req.addr == `PDSP_A_PEAK_USR);
    assign clr_rev = req.wr && (req.addr == `PDSP_A_PEAK_REV);
    assign peak_usr_base = clr_usr ? `PDSP_ZERO32 : peak_usr_q;
    assign peak_rev_base = clr_rev ? `PDSP_ZERO32 : peak_rev_q;

    // user-unit peak
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            peak_usr_q <= `PDSP_ZERO32;
        end else if (abs_usr > peak_usr_base) begin
            peak_usr_q <= abs_usr;
        end else begin
            peak_usr_q <= peak_usr_base;
        end
    end

    // revolution peak
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            peak_rev_q <= `PDSP_ZERO32;
        end else if (abs_rev > peak_rev_base) begin
            peak_rev_q <= abs_rev;
        end else begin
            peak_rev_q <= peak_rev_base;
        end
    end

    // ----------------------------------------------------------------
    // rescale status
    // ----------------------------------------------------------------
    // error beats done beats start beats init when they coincide
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rs_q <= PDSP_RS_ACTIVE;
        end else begin
            case (1'b1)
                rescale.fail: rs_q <= PDSP_RS_ERROR;
                rescale.done: rs_q <= PDSP_RS_DONE;
                rescale.start: rs_q <= PDSP_RS_ACTIVE;
                rescale.init_ok: rs_q <= PDSP_RS_INIT;
                default: rs_q <= rs_q;
            endcase
        end
    end

    // error details latch with the error state, kept until the next error
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_info_q <= `PDSP_ZERO32;
        end else if (rescale.fail) begin
            err_info_q[`PDSP_ERR_ADDR_MSB:`PDSP_ERR_ADDR_LSB] <= rescale.err_param;
            err_info_q[`PDSP_ERR_SET_MSB:`PDSP_ERR_SET_LSB] <= rescale.err_set;
        end
    end

    // ----------------------------------------------------------------
    // compare channel flags
    // ----------------------------------------------------------------
    for (genvar i = 0; i < CHAN_N; i++) begin : g_flag
        // bit i follows channel i+1
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                flags_q[i] <= 1'b0;
            end else begin
                flags_q[i] <= cmp_met[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // parameter access
    // ----------------------------------------------------------------
    // read decode, narrow values zero-extended
    always_comb begin
        rd_mux = `PDSP_ZERO32;
        hit = 1'b1;
        ro_hit = 1'b1;
        case (req.addr)
            `PDSP_A_RESCALE_STATE: rd_mux = {29'h0000_0000, rs_q};
            `PDSP_A_RESCALE_ERROR: rd_mux = err_info_q;
            `PDSP_A_CMP_FLAGS: rd_mux[CHAN_N-1:0] = flags_q;
            `PDSP_A_SETP_INT: rd_mux = ref_int_q;
            `PDSP_A_SETP_USR: rd_mux = ref_usr_q;
            `PDSP_A_TOTAL_DEV_USR: rd_mux = total_dev_q;
            `PDSP_A_LOAD_DEV_USR: rd_mux = load_dev_q;
            `PDSP_A_PEAK_USR: begin
                rd_mux = peak_usr_q;
                ro_hit = 1'b0;
            end
            `PDSP_A_PEAK_REV: begin
                rd_mux = peak_rev_q;
                ro_hit = 1'b0;
            end
            default: begin
                hit = 1'b0;
                ro_hit = 1'b0;
            end
        endcase
    end

    // read answer one cycle after the request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= `PDSP_ZERO32;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= req.rd;
            rd_data_q <= req.rd ? rd_mux : `PDSP_ZERO32;
        end
    end

    // unmapped access or write to a read-only parameter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_err_q <= 1'b0;
        end else begin
            acc_err_q <= ((req.rd || req.wr) && !hit) || (req.wr && ro_hit);
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_fail;
        rescale.fail;
    endsequence

    sequence s_peak_clr_usr;
        req.wr && req.addr == `PDSP_A_PEAK_USR;
    endsequence

    sequence s_quiet_usr;
        !(req.wr && req.addr == `PDSP_A_PEAK_USR) && abs_usr <= peak_usr_q;
    endsequence

    AST_PEAK_COVERS: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> peak_usr_q >= $past(abs_usr) && peak_rev_q >= $past(abs_rev))
        else $error("peak below observed deviation");

    AST_PEAK_HOLDS: assert property (@(posedge clk) disable iff (!rst_n)
        s_quiet_usr |=> $stable(peak_usr_q))
        else $error("user peak changed without cause");

    AST_PEAK_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        s_peak_clr_usr |=> peak_usr_q == $past(abs_usr))
        else $error("user peak not restarted by write");

    AST_REV_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        req.wr && req.addr == `PDSP_A_PEAK_REV |=> peak_rev_q == $past(abs_rev))
        else $error("revolution peak not restarted by write");

    AST_USR_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
        !peak_usr_q[`PDSP_SIGN_BIT])
        else $error("user peak negative");

    AST_LOAD_DEV: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> load_dev_q == $past(ref_pos_usr) - $past(load_pos_usr) && follow_dev_q == load_dev_q)
        else $error("load deviation wrong");

    AST_TOTAL_DEV: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> total_dev_q == load_dev_q + $past(dyn_dev_usr))
        else $error("total deviation wrong");

    AST_REF_READ: assert property (@(posedge clk) disable iff (!rst_n)
        req.rd && req.addr == `PDSP_A_SETP_USR |=> rd_valid_q && rd_data_q == $past(ref_usr_q))
        else $error("reference read wrong");

    AST_ERR_FIELDS: assert property (@(posedge clk) disable iff (!rst_n)
        s_fail |=> err_info_q[`PDSP_ERR_ADDR_MSB:`PDSP_ERR_ADDR_LSB] == $past(rescale.err_param)
            && err_info_q[`PDSP_ERR_SET_MSB:`PDSP_ERR_SET_LSB] == $past(rescale.err_set))
        else $error("rescale error fields wrong");

    AST_ERR_WITH_STATE: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(err_info_q) |-> rs_q == PDSP_RS_ERROR)
        else $error("error info changed apart from error state");

    AST_STATE_CODE: assert property (@(posedge clk) disable iff (!rst_n)
        s_fail ##1 !rescale.start && !rescale.done && !rescale.init_ok |-> rs_q == PDSP_RS_ERROR)
        else $error("error state not held");

    AST_FLAGS: assert property (@(posedge clk) disable iff (!rst_n)
        req.rd && req.addr == `PDSP_A_CMP_FLAGS |=> rd_data_q[CHAN_N-1:0] == $past(flags_q))
        else $error("compare flags read wrong");

    AST_REV_HOLDS: assert property (@(posedge clk) disable iff (!rst_n)
        !clr_rev && abs_rev <= peak_rev_q |=> $stable(peak_rev_q))
        else $error("revolution peak changed without cause");

    AST_REV_READ: assert property (@(posedge clk) disable iff (!rst_n)
        req.rd && req.addr == `PDSP_A_PEAK_REV |=> rd_data_q == $past(peak_rev_q))
        else $error("revolution peak read wrong");

    AST_USR_READ_SIGN: assert property (@(posedge clk) disable iff (!rst_n)
        req.rd && req.addr == `PDSP_A_PEAK_USR |=> !rd_data_q[`PDSP_SIGN_BIT])
        else $error("user peak read negative");

    AST_INT_READ: assert property (@(posedge clk) disable iff (!rst_n)
        req.rd && req.addr == `PDSP_A_SETP_INT |=> rd_data_q == $past(ref_int_q))
        else $error("internal reference read wrong");

    AST_ERR_KEPT: assert property (@(posedge clk) disable iff (!rst_n)
        !rescale.fail |=> $stable(err_info_q))
        else $error("error info changed without an error");

    AST_STATE_DONE: assert property (@(posedge clk) disable iff (!rst_n)
        rescale.done && !rescale.fail |=> rs_q == PDSP_RS_DONE)
        else $error("done state not reported");

    AST_STATE_ACTIVE: assert property (@(posedge clk) disable iff (!rst_n)
        rescale.start && !rescale.fail && !rescale.done |=> rs_q == PDSP_RS_ACTIVE)
        else $error("active state not reported");

    AST_STATE_INIT: assert property (@(posedge clk) disable iff (!rst_n)
        rescale.init_ok && !rescale.fail && !rescale.done && !rescale.start |=> rs_q == PDSP_RS_INIT)
        else $error("initialised state not reported");

    sequence s_rd_state;
        req.rd && req.addr == `PDSP_A_RESCALE_STATE;
    endsequence

    AST_STATE_READ: assert property (@(posedge clk) disable iff (!rst_n)
        s_rd_state |=> rd_data_q == {29'h0000_0000, $past(rs_q)})
        else $error("state read wrong");

    AST_CHAN_MAP: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> flags_q == $past(cmp_met))
        else $error("channel flags do not follow comparisons");

endmodule : pdsp_top

// >>> verification/pdsp_master.sv
// Purpose: fieldbus master model issuing parameter reads and writes
// Assumes: one access per cycle, answer one cycle after the request
// Notes: an idle bus shows the inverse of the last address and data
`timescale 1ns/100ps

module pdsp_master import pdsp_pkg::*; (
    input wire logic clk,
    output pdsp_req_t req,
    input wire logic [31:0] rd_data_q,
    input wire logic rd_valid_q,
    input wire logic acc_err_q
);
    initial req = '0;

    // ----------------------------------------------------------------
    // access task
    // ----------------------------------------------------------------
    // request held over one edge, answer taken in the following cycle
    task automatic access(input logic rd, input logic wr, input logic [15:0] addr,
                          output logic [31:0] data, output logic vld, output logic err);
        @(posedge clk);
        req <= '{rd: rd, wr: wr, addr: addr, data: 32'h5A5A_5A5A};
        @(posedge clk);
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, data: 32'hA5A5_A5A5};
        @(negedge clk);
        data = rd_data_q;
        vld = rd_valid_q;
        err = acc_err_q;
    endtask : access
endmodule : pdsp_master

// >>> verification/pdsp_top_test.sv
// Purpose: self-checking bench of the deviation and status parameter set
// Assumes: inputs driven by non-blocking assignment at the rising edge
// Notes: expected values are derived from the register map by hand
`timescale 1ns/100ps
`include "pdsp_cfg.svh"

module pdsp_top_test import pdsp_pkg::*; ;
    logic clk;
    logic rst_n;
    pdsp_req_t req;
    logic [31:0] ref_pos_usr, ref_pos_int, load_pos_usr, dyn_dev_usr, load_dev_rev;
    pdsp_rescale_t rescale;
    logic [3:0] cmp_met;
    logic [31:0] rd_data_q, follow_dev_q;
    logic rd_valid_q, acc_err_q;
    int err_count, num_checks;
    logic [3:0] ev [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
    logic [2:0] code [4] = '{3'h0, 3'h2, 3'h3, 3'h4};

    pdsp_top DUT (.clk(clk), .rst_n(rst_n), .req(req), .ref_pos_usr(ref_pos_usr),
        .ref_pos_int(ref_pos_int), .load_pos_usr(load_pos_usr), .dyn_dev_usr(dyn_dev_usr),
        .load_dev_rev(load_dev_rev), .rescale(rescale), .cmp_met(cmp_met),
        .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .acc_err_q(acc_err_q),
        .follow_dev_q(follow_dev_q));

    pdsp_master m (.clk(clk), .req(req), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
        .acc_err_q(acc_err_q));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // read one parameter and compare data, valid and error flag
    task automatic rd(input string name, input logic [15:0] a, input logic [31:0] exp,
                      input logic experr);
        logic [31:0] d;
        logic v, e;
        m.access(1'b1, 1'b0, a, d, v, e);
        chk(name, d, exp);
        chk({name, "_valid"}, {31'h0, v}, 32'h1);
        chk({name, "_err"}, {31'h0, e}, {31'h0, experr});
    endtask : rd

    task automatic wr(input logic [15:0] a, input logic experr);
        logic [31:0] d;
        logic v, e;
        m.access(1'b0, 1'b1, a, d, v, e);
        chk("wr_err", {31'h0, e}, {31'h0, experr});
        chk("wr_valid", {31'h0, v}, 32'h0);
    endtask : wr

    // apply position inputs, then let the pipeline settle
    task automatic set_pos(input logic [31:0] ru, input logic [31:0] ri, input logic [31:0] lp,
                           input logic [31:0] dy, input logic [31:0] rv);
        @(posedge clk);
        ref_pos_usr <= ru;
        ref_pos_int <= ri;
        load_pos_usr <= lp;
        dyn_dev_usr <= dy;
        load_dev_rev <= rv;
        repeat (3) @(posedge clk);
    endtask : set_pos

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    // ----------------------------------------------------------------
    // clock and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        finish_test();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        err_count = 0;
        num_checks = 0;
        rst_n = 1'b0;
        ref_pos_usr = '0;
        ref_pos_int = '0;
        load_pos_usr = '0;
        dyn_dev_usr = '0;
        load_dev_rev = '0;
        rescale = '0;
        cmp_met = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd("state", `PDSP_A_RESCALE_STATE, 32'h0, 1'b0);
        rd("peak_usr", `PDSP_A_PEAK_USR, 32'h0, 1'b0);
        // deviation arithmetic and peak capture
        set_pos(32'h0000_0100, 32'hFEDC_BA98, 32'h0000_0180, 32'h0000_0010, 32'hFFFF_FFF0);
        rd("setp_usr", `PDSP_A_SETP_USR, 32'h0000_0100, 1'b0);
        rd("setp_int", `PDSP_A_SETP_INT, 32'hFEDC_BA98, 1'b0);
        rd("load_dev", `PDSP_A_LOAD_DEV_USR, 32'hFFFF_FF80, 1'b0);
        chk("follow_dev", follow_dev_q, 32'hFFFF_FF80);
        rd("total_dev", `PDSP_A_TOTAL_DEV_USR, 32'hFFFF_FF90, 1'b0);
        rd("peak_usr", `PDSP_A_PEAK_USR, 32'h0000_0080, 1'b0);
        rd("peak_rev", `PDSP_A_PEAK_REV, 32'h0000_0010, 1'b0);
        // smaller deviation keeps peak, write restarts from current magnitude
        set_pos(32'h0000_0100, 32'h0, 32'h0000_00F0, 32'h0, 32'h0000_0003);
        rd("peak_keep", `PDSP_A_PEAK_USR, 32'h0000_0080, 1'b0);
        wr(`PDSP_A_PEAK_USR, 1'b0);
        rd("peak_clr", `PDSP_A_PEAK_USR, 32'h0000_0010, 1'b0);
        wr(`PDSP_A_PEAK_REV, 1'b0);
        rd("peak_rev_clr", `PDSP_A_PEAK_REV, 32'h0000_0003, 1'b0);
        // refused accesses
        wr(`PDSP_A_SETP_USR, 1'b1);
        rd("unmapped", 16'h0000, 32'h0, 1'b1);
        // extreme negative deviation
        set_pos(32'h0, 32'h0, 32'h8000_0000, 32'h0, 32'h8000_0000);
        rd("load_min", `PDSP_A_LOAD_DEV_USR, 32'h8000_0000, 1'b0);
        rd("peak_sat", `PDSP_A_PEAK_USR, 32'h7FFF_FFFF, 1'b0);
        rd("peak_rev_max", `PDSP_A_PEAK_REV, 32'h8000_0000, 1'b0);
        // rescale events: start, done, fail, init
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            rescale <= {ev[i], 16'h1234, 16'h0007};
            @(posedge clk);
            rescale <= '0;
            rd("state", `PDSP_A_RESCALE_STATE, {29'h0, code[i]}, 1'b0);
            if (i == 2) begin
                rd("err_info", `PDSP_A_RESCALE_ERROR, 32'h0007_1234, 1'b0);
            end
        end
        // mid-run reset returns state and error info to their idle values
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd("state_rst", `PDSP_A_RESCALE_STATE, 32'h0, 1'b0);
        rd("err_rst", `PDSP_A_RESCALE_ERROR, 32'h0, 1'b0);
        // one channel at a time
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            cmp_met <= 4'h1 << i;
            repeat (2) @(posedge clk);
            rd("flags", `PDSP_A_CMP_FLAGS, 32'h1 << i, 1'b0);
        end
        finish_test();
    end
endmodule : pdsp_top_test
